/* File: core/lfr_pkg.sv */
// Constants shared by both ends of the LAN function reset control link.
// Assumes a single 20 MHz clock domain on both ends.
package lfr_pkg;
  localparam int NVF          = 8;
  localparam int CLK_MHZ      = 20;
  localparam int T_QUIET_NS   = 10000;
  localparam int QUIET_CYC    = (T_QUIET_NS * CLK_MHZ + 999) / 1000;
  localparam int FLR_DLY_DEF  = 1;
  localparam int FORCE_BIT    = 0;
  // Host register byte offsets
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_VFCMD = 8'h04;
  localparam logic [7:0] A_CTRL  = 8'h08;
  localparam logic [7:0] A_MGMT  = 8'h0C;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam logic [7:0] A_DONE  = 8'h14;
  localparam logic [7:0] A_RIP   = 8'h18;
  localparam logic [7:0] A_BQREL = 8'h1C;
  // Command register bits
  localparam int CMD_SW      = 0;
  localparam int CMD_LINK    = 1;
  localparam int CMD_PHY     = 2;
  localparam int CMD_PFFLR   = 3;
  localparam int CMD_D3D0    = 4;
  localparam int CMD_PRERST  = 5;
  localparam int CMD_CFGDONE = 6;
  localparam int CMD_PHYSKIP = 7;
  // Control register bits and reset value
  localparam int CTRL_IOV    = 0;
  localparam int CTRL_IORST  = 1;
  localparam int CTRL_RPE    = 2;
  localparam logic [2:0] CTRL_RST = 3'h4;
  // Management, VF command and blocked queue release register fields
  localparam int MGMT_CMD    = 8;
  localparam int MGMT_FWRST  = 9;
  localparam int VFCMD_SOFT  = 8;
  localparam int BQ_TX       = 8;
  typedef enum logic [1:0] {
    LFR_PR_IDLE  = 2'h0,
    LFR_PR_DRAIN = 2'h1,
    LFR_PR_ACK   = 2'h2
  } lfr_pr_t;
  typedef enum logic [2:0] {
    LFR_SQ_IDLE   = 3'h0,
    LFR_SQ_QUIET1 = 3'h1,
    LFR_SQ_POLL   = 3'h2,
    LFR_SQ_QUIET2 = 3'h3,
    LFR_SQ_VETO   = 3'h4,
    LFR_SQ_PHY    = 3'h5
  } lfr_sq_t;
endpackage : lfr_pkg

/* File: core/lfr_if.sv */
// Link between the host fabric end and the LAN reset control end.
// Assumes both ends share hclk; every signal is driven from a flip-flop.
`timescale 1ns/1ns
`default_nettype none
interface lfr_if #(parameter int NVF = lfr_pkg::NVF);
  logic           io_rst_n;
  logic           prereset_msg;
  logic           prereset_ack;
  logic           new_req;
  logic           req_ur;
  logic           d3_to_d0;
  logic           pf_flr;
  logic [NVF-1:0] vf_flr;
  logic [NVF-1:0] vf_soft_reset_bit;
  logic           iov_enable;
  logic           sw_reset;
  logic           link_reset_bit;
  logic           phy_reset;
  logic           phy_owned;
  logic           mgmt_fw_port_reset;
  logic           mgmt_force_cmd;
  logic [7:0]     mgmt_force_data;
  logic           pf_config_done_bit;
  logic [NVF-1:0] done_read;
  logic [NVF-1:0] reset_done_flag;
  logic [NVF-1:0] reset_in_progress_flag;
  logic           rx_pause_honor_enable;
  logic           tc_xon_state;
  logic           mgmt_link_veto;
  logic [NVF-1:0] rx_blocked_queue_release;
  logic [NVF-1:0] tx_blocked_queue_release;
  modport dev (
    input  io_rst_n, prereset_msg, new_req, d3_to_d0, pf_flr, vf_flr, vf_soft_reset_bit,
           iov_enable, sw_reset, link_reset_bit, phy_reset, phy_owned, mgmt_fw_port_reset,
           mgmt_force_cmd, mgmt_force_data, pf_config_done_bit, done_read,
           rx_pause_honor_enable, rx_blocked_queue_release, tx_blocked_queue_release,
    output prereset_ack, req_ur, reset_done_flag, reset_in_progress_flag, tc_xon_state,
           mgmt_link_veto
  );
  modport host (
    output io_rst_n, prereset_msg, new_req, d3_to_d0, pf_flr, vf_flr, vf_soft_reset_bit,
           iov_enable, sw_reset, link_reset_bit, phy_reset, phy_owned, mgmt_fw_port_reset,
           mgmt_force_cmd, mgmt_force_data, pf_config_done_bit, done_read,
           rx_pause_honor_enable, rx_blocked_queue_release, tx_blocked_queue_release,
    input  prereset_ack, req_ur, reset_done_flag, reset_in_progress_flag, tc_xon_state,
           mgmt_link_veto
  );
endinterface : lfr_if
`default_nettype wire

/* File: core/lfr_dev.sv */
// LAN function reset control: reset hierarchy, graceful pre-reset drain,
// FLR delay, per-VF reset, reset-in-progress and reset-done flags.
// Assumes hresetn is power-good and all link inputs are synchronous to hclk.
`timescale 1ns/1ns
`default_nettype none
module lfr_dev #(
  parameter int NVF = lfr_pkg::NVF
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  lfr_if.dev                  bus,
  input  wire logic           cpl_pending,
  input  wire logic           npr_pending,
  input  wire logic           wol_mng_keep,
  input  wire logic           flr_delay_dis,
  input  wire logic [7:0]     flr_delay,
  input  wire logic           force_rst_en,
  input  wire logic           tc_xon_in,
  input  wire logic           veto_in,
  input  wire logic [NVF-1:0] malicious,
  output logic                req_issue_en,
  output logic                blk_rst,
  output logic                mac_rst,
  output logic                phy_rst,
  output logic                an_restart,
  output logic                fn_rst,
  output logic                fn_cfg_rst,
  output logic                flash_reload,
  output logic                rx_pause_en,
  output logic [NVF-1:0]      vf_rst,
  output logic [NVF-1:0]      vf_cfg_rst,
  output logic [NVF-1:0]      vf_gate,
  output logic [NVF-1:0]      vf_drop_rd,
  output logic [NVF-1:0]      vf_blocked
);
  logic                io_prev_reg;
  logic                iov_prev_reg;
  logic [7:0]          flr_cnt_reg;
  logic                pf_pend_reg;
  logic [NVF-1:0]      vf_pend_reg;
  lfr_pkg::lfr_pr_t    pr_reg;
  lfr_pkg::lfr_pr_t    pr_next;

  // Edge detection of I/O reset release and virtualization disable
  wire io_ev   = bus.io_rst_n & ~io_prev_reg;
  wire iov_off = iov_prev_reg & ~bus.iov_enable;
  wire force_ev = force_rst_en & (bus.mgmt_fw_port_reset |
                  (bus.mgmt_force_cmd & bus.mgmt_force_data[lfr_pkg::FORCE_BIT]));

  // FLR latency counter
  wire [7:0] flr_lat  = (flr_delay_dis || flr_delay == 8'h00) ?
                        8'(lfr_pkg::FLR_DLY_DEF) : flr_delay;
  wire       flr_req  = bus.pf_flr | (|bus.vf_flr);
  wire       flr_fire = (flr_cnt_reg == 8'h01);
  wire       flr_idle = (flr_cnt_reg == 8'h00);
  wire       flr_load = flr_req & (flr_idle | flr_fire);
  wire [7:0] flr_cnt_next = flr_load ? flr_lat :
                            flr_idle ? 8'h00 : flr_cnt_reg - 8'h01;
  wire                 pf_flr_go = flr_fire & pf_pend_reg;
  wire [NVF-1:0]       vf_flr_go = flr_fire ? vf_pend_reg : '0;

  // Reset ranking: each level feeds all lower levels, except that I/O reset does not feed PHY reset while wol_mng_keep is set
  wire pf_any = io_ev | pf_flr_go | bus.d3_to_d0 | bus.sw_reset |
                bus.link_reset_bit | force_ev;
  wire pf_cfg = io_ev | pf_flr_go;
  wire [NVF-1:0] vf_ev  = vf_flr_go | bus.vf_soft_reset_bit;
  wire [NVF-1:0] vf_any = {NVF{pf_any}} | vf_ev |
                          {NVF{iov_off}};
  wire [NVF-1:0] vf_cfg = {NVF{pf_cfg}} | vf_flr_go | {NVF{iov_off}};
  wire mac_ev  = io_ev | bus.link_reset_bit | force_ev;

  // PHY reset sources
  wire io_phy  = io_ev & ~wol_mng_keep;
  wire phy_cmd = bus.phy_reset & bus.phy_owned;
  wire phy_ev  = io_phy | bus.link_reset_bit | phy_cmd;

  // Flag updates; a set in the clearing cycle wins
  wire           cfg_done  = bus.pf_config_done_bit;
  wire           done_set  = pf_flr_go | cfg_done;
  wire [NVF-1:0] done_next = (bus.reset_done_flag & ~bus.done_read) |
                             {NVF{done_set}};
  wire [NVF-1:0] rip_next  = pf_any ? {NVF{1'b1}} :
                             cfg_done ? '0 :
                             bus.reset_in_progress_flag;
  wire [NVF-1:0] gate_next = vf_any | (vf_gate & ~{NVF{cfg_done}});
  wire [NVF-1:0] blk_next  = (vf_blocked & ~(bus.rx_blocked_queue_release |
                             bus.tx_blocked_queue_release)) | malicious;

  // Pre-reset decodes
  wire drained      = ~cpl_pending & ~npr_pending;
  wire pr_busy      = (pr_reg != lfr_pkg::LFR_PR_IDLE);
  wire pr_idle_next = (pr_next == lfr_pkg::LFR_PR_IDLE);
  wire pr_ack_next  = (pr_next == lfr_pkg::LFR_PR_ACK);

  // Graceful pre-reset drain
  always_comb begin
    pr_next = pr_reg;
    unique case (pr_reg)
      lfr_pkg::LFR_PR_IDLE: begin
        if (bus.prereset_msg) pr_next = lfr_pkg::LFR_PR_DRAIN;
      end
      lfr_pkg::LFR_PR_DRAIN: begin
        if (drained) pr_next = lfr_pkg::LFR_PR_ACK;
      end
      lfr_pkg::LFR_PR_ACK: begin
        if (io_ev) pr_next = lfr_pkg::LFR_PR_IDLE;
      end
      default: pr_next = lfr_pkg::LFR_PR_IDLE;
    endcase
  end

  // Power-good holds everything in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_prev_reg  <= 1'b1;
      iov_prev_reg <= 1'b0;
      flr_cnt_reg  <= 8'h00;
      pf_pend_reg  <= 1'b0;
      vf_pend_reg  <= '0;
      pr_reg       <= lfr_pkg::LFR_PR_IDLE;
    end else begin
      io_prev_reg  <= bus.io_rst_n;
      iov_prev_reg <= bus.iov_enable;
      flr_cnt_reg  <= flr_cnt_next;
      pf_pend_reg  <= (pf_pend_reg & ~flr_fire) | bus.pf_flr;
      vf_pend_reg  <= (flr_fire ? '0 : vf_pend_reg) | bus.vf_flr;
      pr_reg       <= pr_next;
    end
  end

  // Link answers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus.prereset_ack           <= 1'b0;
      bus.req_ur                 <= 1'b0;
      bus.reset_done_flag        <= '0;
      bus.reset_in_progress_flag <= '0;
      bus.tc_xon_state           <= 1'b0;
      bus.mgmt_link_veto         <= 1'b0;
      req_issue_en               <= 1'b1;
    end else begin
      bus.prereset_ack           <= pr_ack_next;
      bus.req_ur                 <= bus.new_req & pr_busy;
      bus.reset_done_flag        <= done_next;
      bus.reset_in_progress_flag <= rip_next;
      bus.tc_xon_state           <= tc_xon_in;
      bus.mgmt_link_veto         <= veto_in;
      req_issue_en               <= pr_idle_next;
    end
  end

  // Reset strobes to the function and its virtual functions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_rst      <= 1'b0;
      mac_rst      <= 1'b0;
      phy_rst      <= 1'b0;
      an_restart   <= 1'b0;
      fn_rst       <= 1'b0;
      fn_cfg_rst   <= 1'b0;
      flash_reload <= 1'b0;
      rx_pause_en  <= 1'b0;
      vf_rst       <= '0;
      vf_cfg_rst   <= '0;
      vf_gate      <= {NVF{1'b1}};
      vf_drop_rd   <= '0;
      vf_blocked   <= '0;
    end else begin
      blk_rst      <= io_ev;
      mac_rst      <= mac_ev;
      phy_rst      <= phy_ev;
      an_restart   <= phy_ev;
      fn_rst       <= pf_any;
      fn_cfg_rst   <= pf_cfg;
      flash_reload <= pf_any & ~io_ev;
      rx_pause_en  <= bus.rx_pause_honor_enable;
      vf_rst       <= vf_any;
      vf_cfg_rst   <= vf_cfg;
      vf_gate      <= gate_next;
      vf_drop_rd   <= vf_any;
      vf_blocked   <= blk_next;
    end
  end
endmodule : lfr_dev
`default_nettype wire

/* File: core/lfr_host.sv */
// Host fabric end: AHB-Lite register slave driving the reset control link,
// with the software-reset quiet sequence and the PHY reset ownership flow.
// Assumes one AHB-Lite master, single word transfers, hclk shared with the link.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module lfr_host #(
  parameter int NVF = lfr_pkg::NVF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        req_in,
  output logic             mgmt_tc_remap,
  lfr_if.host              bus
);
  logic                wact_reg;
  logic [7:0]          waddr_reg;
  logic [2:0]          ctrl_reg;
  logic [2*NVF-1:0]    bq_reg;
  logic                ack_seen_reg;
  logic                skipped_reg;
  logic                link_kind_reg;
  logic [7:0]          ur_cnt_reg;
  logic [15:0]         cnt_reg;
  lfr_pkg::lfr_sq_t    sq_reg;
  lfr_pkg::lfr_sq_t    sq_next;

  wire acc    = hsel & htrans[1] & hready & (hsize == 3'h2);
  wire rd_acc = acc & ~hwrite;
  wire [7:0] ra = haddr[7:0];
  wire wr_cmd  = wact_reg & (waddr_reg == lfr_pkg::A_CMD);
  wire wr_vf   = wact_reg & (waddr_reg == lfr_pkg::A_VFCMD);
  wire wr_ctrl = wact_reg & (waddr_reg == lfr_pkg::A_CTRL);
  wire wr_mgmt = wact_reg & (waddr_reg == lfr_pkg::A_MGMT);
  wire wr_bq   = wact_reg & (waddr_reg == lfr_pkg::A_BQREL);
  wire idle    = (sq_reg == lfr_pkg::LFR_SQ_IDLE);
  wire go_sw   = wr_cmd & idle & (hwdata[lfr_pkg::CMD_SW] | hwdata[lfr_pkg::CMD_LINK]);
  wire go_phy  = wr_cmd & idle & hwdata[lfr_pkg::CMD_PHY] & ~go_sw;
  wire veto_skip = go_phy & bus.mgmt_link_veto & hwdata[lfr_pkg::CMD_PHYSKIP];
  wire cnt_done = (cnt_reg == 16'h0000);
  wire [NVF-1:0] vf_hit = wr_vf ? (hwdata[NVF-1:0] | hwdata[lfr_pkg::VFCMD_SOFT +: NVF]) : '0;
  wire [31:0] stat = {16'h0000, ur_cnt_reg, 2'h0, bus.phy_owned, skipped_reg,
                      ~idle, bus.mgmt_link_veto, bus.tc_xon_state, ack_seen_reg};
  wire [31:0] rd_val =
    (ra == lfr_pkg::A_CTRL)  ? {29'h0, ctrl_reg} :
    (ra == lfr_pkg::A_STAT)  ? stat :
    (ra == lfr_pkg::A_DONE)  ? 32'(bus.reset_done_flag) :
    (ra == lfr_pkg::A_RIP)   ? 32'(bus.reset_in_progress_flag) :
    (ra == lfr_pkg::A_BQREL) ? {16'h0000, 8'(bq_reg[2*NVF-1:NVF]), 8'(bq_reg[NVF-1:0])} :
    32'h0000_0000;

  // Quiet sequence before software or link reset, and PHY ownership flow
  always_comb begin
    sq_next = sq_reg;
    unique case (sq_reg)
      lfr_pkg::LFR_SQ_IDLE: begin
        if (go_sw) sq_next = lfr_pkg::LFR_SQ_QUIET1;
        else if (go_phy && !veto_skip) sq_next = lfr_pkg::LFR_SQ_VETO;
      end
      lfr_pkg::LFR_SQ_QUIET1: begin
        if (cnt_done) sq_next = lfr_pkg::LFR_SQ_POLL;
      end
      lfr_pkg::LFR_SQ_POLL: begin
        if (!bus.tc_xon_state) sq_next = lfr_pkg::LFR_SQ_QUIET2;
      end
      lfr_pkg::LFR_SQ_QUIET2: begin
        if (cnt_done) sq_next = lfr_pkg::LFR_SQ_IDLE;
      end
      lfr_pkg::LFR_SQ_VETO: begin
        if (!bus.mgmt_link_veto) sq_next = lfr_pkg::LFR_SQ_PHY;
      end
      lfr_pkg::LFR_SQ_PHY: sq_next = lfr_pkg::LFR_SQ_IDLE;
      default: sq_next = lfr_pkg::LFR_SQ_IDLE;
    endcase
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wact_reg  <= 1'b0;
      waddr_reg <= 8'h00;
      bus.done_read <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= rd_acc ? rd_val : 32'h0000_0000;
      wact_reg  <= acc & hwrite;
      waddr_reg <= ra;
      bus.done_read <= (rd_acc && ra == lfr_pkg::A_DONE) ? bus.reset_done_flag : '0;
    end
  end

  // Registers and sequence state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg      <= lfr_pkg::CTRL_RST;
      bq_reg        <= '0;
      ack_seen_reg  <= 1'b0;
      skipped_reg   <= 1'b0;
      link_kind_reg <= 1'b0;
      ur_cnt_reg    <= 8'h00;
      cnt_reg       <= 16'h0000;
      sq_reg        <= lfr_pkg::LFR_SQ_IDLE;
    end else begin
      sq_reg <= sq_next;
      if (wr_ctrl) ctrl_reg <= hwdata[2:0];
      else if (go_sw) ctrl_reg[lfr_pkg::CTRL_RPE] <= 1'b0;
      if (wr_bq) bq_reg <= {hwdata[lfr_pkg::BQ_TX +: NVF], hwdata[NVF-1:0]};
      else bq_reg <= bq_reg & ~{vf_hit, vf_hit};
      if (bus.prereset_ack) ack_seen_reg <= 1'b1;
      else if (wr_cmd && hwdata[lfr_pkg::CMD_PRERST]) ack_seen_reg <= 1'b0;
      if (veto_skip) skipped_reg <= 1'b1;
      else if (go_phy) skipped_reg <= 1'b0;
      if (go_sw) link_kind_reg <= hwdata[lfr_pkg::CMD_LINK];
      if (bus.req_ur) ur_cnt_reg <= ur_cnt_reg + 8'h01;
      if (go_sw || (sq_reg == lfr_pkg::LFR_SQ_POLL && !bus.tc_xon_state))
        cnt_reg <= 16'(lfr_pkg::QUIET_CYC);
      else if (!cnt_done) cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // Link strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus.io_rst_n              <= 1'b1;
      bus.iov_enable            <= 1'b0;
      bus.rx_pause_honor_enable <= 1'b0;
      bus.prereset_msg          <= 1'b0;
      bus.new_req               <= 1'b0;
      bus.d3_to_d0              <= 1'b0;
      bus.pf_flr                <= 1'b0;
      bus.vf_flr                <= '0;
      bus.vf_soft_reset_bit     <= '0;
      bus.sw_reset              <= 1'b0;
      bus.link_reset_bit        <= 1'b0;
      bus.phy_reset             <= 1'b0;
      bus.phy_owned             <= 1'b0;
      bus.mgmt_fw_port_reset    <= 1'b0;
      bus.mgmt_force_cmd        <= 1'b0;
      bus.mgmt_force_data       <= 8'h00;
      bus.pf_config_done_bit    <= 1'b0;
      bus.rx_blocked_queue_release <= '0;
      bus.tx_blocked_queue_release <= '0;
      mgmt_tc_remap             <= 1'b0;
    end else begin
      bus.io_rst_n              <= ~ctrl_reg[lfr_pkg::CTRL_IORST];
      bus.iov_enable            <= ctrl_reg[lfr_pkg::CTRL_IOV];
      bus.rx_pause_honor_enable <= ctrl_reg[lfr_pkg::CTRL_RPE];
      bus.prereset_msg          <= wr_cmd & hwdata[lfr_pkg::CMD_PRERST];
      bus.new_req               <= req_in;
      bus.d3_to_d0              <= wr_cmd & hwdata[lfr_pkg::CMD_D3D0];
      bus.pf_flr                <= wr_cmd & hwdata[lfr_pkg::CMD_PFFLR];
      bus.vf_flr                <= wr_vf ? hwdata[NVF-1:0] : '0;
      bus.vf_soft_reset_bit     <= wr_vf ? hwdata[lfr_pkg::VFCMD_SOFT +: NVF] : '0;
      bus.sw_reset <= (sq_reg == lfr_pkg::LFR_SQ_QUIET2) & cnt_done & ~link_kind_reg;
      bus.link_reset_bit <= (sq_reg == lfr_pkg::LFR_SQ_QUIET2) & cnt_done & link_kind_reg;
      bus.phy_reset <= (sq_reg == lfr_pkg::LFR_SQ_PHY);
      bus.phy_owned <= (sq_reg == lfr_pkg::LFR_SQ_PHY);
      bus.mgmt_fw_port_reset    <= wr_mgmt & hwdata[lfr_pkg::MGMT_FWRST];
      bus.mgmt_force_cmd        <= wr_mgmt & hwdata[lfr_pkg::MGMT_CMD];
      if (wr_mgmt) bus.mgmt_force_data <= hwdata[7:0];
      bus.pf_config_done_bit    <= wr_cmd & hwdata[lfr_pkg::CMD_CFGDONE];
      bus.rx_blocked_queue_release <= bq_reg[NVF-1:0];
      bus.tx_blocked_queue_release <= bq_reg[2*NVF-1:NVF];
      mgmt_tc_remap <= (sq_reg == lfr_pkg::LFR_SQ_POLL) & ~bus.tc_xon_state;
    end
  end
endmodule : lfr_host
`default_nettype wire

/* File: tb/lfr_link_chk.sv */
// Checker: timing relations on the link between host and device ends.
// Assumes one clock domain; hresetn is the power-good reset of both ends.
`timescale 1ns/1ns
`default_nettype none
module lfr_link_chk #(parameter int NVF = lfr_pkg::NVF) (
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic           new_req,
  input wire logic           req_ur,
  input wire logic           prereset_ack,
  input wire logic           io_rst_n,
  input wire logic           pf_config_done_bit,
  input wire logic [NVF-1:0] reset_done_flag,
  input wire logic [NVF-1:0] reset_in_progress_flag,
  input wire logic           phy_reset,
  input wire logic           phy_owned,
  input wire logic           mgmt_link_veto,
  input wire logic           sw_reset,
  input wire logic           link_reset_bit,
  input wire logic           rx_pause_honor_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ur_has_req: assert property (req_ur |-> $past(new_req))
    else $error("unsupported answer without request");
  a_ack_holds: assert property (prereset_ack && !io_rst_n |=> prereset_ack)
    else $error("acknowledge dropped early");
  a_cfg_sets_done: assert property (pf_config_done_bit |=> reset_done_flag == '1)
    else $error("done flags not set");
  a_cfg_clears_rip: assert property (pf_config_done_bit |=> reset_in_progress_flag == '0)
    else $error("in progress flags not cleared");
  a_phy_owned: assert property (phy_owned == phy_reset)
    else $error("ownership not with phy reset");
  a_phy_no_veto: assert property (phy_reset |-> !$past(mgmt_link_veto, 2))
    else $error("phy reset under veto");
  a_sw_quiet: assert property (sw_reset |-> !rx_pause_honor_enable)
    else $error("sw reset with pause honour on");
  a_link_quiet: assert property (link_reset_bit |-> !rx_pause_honor_enable)
    else $error("link reset with pause honour on");
endmodule : lfr_link_chk
`default_nettype wire

/* File: tb/testbench.sv */
// Testbench: host and device ends joined by the link, driven over AHB-Lite.
// Assumes a 20 MHz hclk and the register map of the package.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, req_in = 1'b0;
  logic        cpl_pending = 1'b0, npr_pending = 1'b0, flr_delay_dis = 1'b1;
  logic        force_rst_en = 1'b1, tc_xon_in = 1'b0, veto_in = 1'b0, wol_mng_keep = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [7:0]  flr_delay = 8'h0, malicious = 8'h0, vr = 8'h0, vd = 8'h0, vc = 8'h0;
  logic [7:0]  s = 8'h0;
  logic        hreadyout, req_issue_en, blk_rst, mac_rst, phy_rst, an_restart, fn_rst;
  logic        fn_cfg_rst, flash_reload, rx_pause_en, mgmt_tc_remap;
  logic [7:0]  vf_rst, vf_cfg_rst, vf_gate, vf_drop_rd, vf_blocked;
  int          n_fail = 0, n_tests = 0, cyc_n = 0, e0 = 0, e1 = 0;
  lfr_if lk ();
  lfr_dev i_lfr_dev (.hclk, .hresetn, .bus(lk), .cpl_pending, .npr_pending,
    .wol_mng_keep, .flr_delay_dis, .flr_delay, .force_rst_en, .tc_xon_in, .veto_in,
    .malicious, .req_issue_en, .blk_rst, .mac_rst, .phy_rst, .an_restart, .fn_rst,
    .fn_cfg_rst, .flash_reload, .rx_pause_en, .vf_rst, .vf_cfg_rst, .vf_gate, .vf_drop_rd,
    .vf_blocked);
  lfr_host i_lfr_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .req_in, .mgmt_tc_remap,
    .bus(lk));
  lfr_link_chk i_lfr_link_chk (.hclk, .hresetn, .new_req(lk.new_req), .req_ur(lk.req_ur),
    .prereset_ack(lk.prereset_ack), .io_rst_n(lk.io_rst_n), .phy_reset(lk.phy_reset),
    .pf_config_done_bit(lk.pf_config_done_bit), .reset_done_flag(lk.reset_done_flag),
    .reset_in_progress_flag(lk.reset_in_progress_flag), .phy_owned(lk.phy_owned),
    .mgmt_link_veto(lk.mgmt_link_veto), .sw_reset(lk.sw_reset),
    .link_reset_bit(lk.link_reset_bit), .rx_pause_honor_enable(lk.rx_pause_honor_enable));
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    s <= s | {mgmt_tc_remap, flash_reload, fn_cfg_rst, fn_rst, an_restart, phy_rst, mac_rst,
              blk_rst};
    vr <= vr | vf_rst;
    vd <= vd | vf_drop_rd;
    vc <= vc | vf_cfg_rst;
    if (lk.pf_flr) e0 <= cyc_n;
    if (fn_rst) e1 <= cyc_n;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction : b
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // Clears the pulse records away from the sampling edge
  task automatic clr();
    @(negedge hclk);
    {s, vr, vd, vc} = '0;
    @(posedge hclk);
  endtask : clr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic t_flr(input logic dis, input logic [7:0] dl, input int l);
    logic [31:0] r;
    flr_delay_dis <= dis;
    flr_delay <= dl;
    wr(lfr_pkg::A_CMD, b(lfr_pkg::CMD_PFFLR));
    cyc(l + 6);
    chk(e1 - e0, l + 1);
    ahb(1'b0, lfr_pkg::A_DONE, 32'h0, r);
    chk(r, 32'hFF);
    ahb(1'b0, lfr_pkg::A_DONE, 32'h0, r);
    chk(r, 32'h0);
    $display("flr test done");
  endtask : t_flr
  task automatic t_pre();
    logic [31:0] r;
    cpl_pending <= 1'b1;
    npr_pending <= 1'b1;
    wr(lfr_pkg::A_CMD, b(lfr_pkg::CMD_PRERST));
    cyc(4);
    chk(req_issue_en, 1'b0);
    req_in <= 1'b1;
    cpl_pending <= 1'b0;
    cyc(1);
    req_in <= 1'b0;
    cyc(4);
    chk(lk.prereset_ack, 1'b0);
    npr_pending <= 1'b0;
    cyc(4);
    chk(lk.prereset_ack, 1'b1);
    ahb(1'b0, lfr_pkg::A_STAT, 32'h0, r);
    chk(r[15:8], 8'h01);
    clr();
    wr(lfr_pkg::A_CTRL, 32'h6);
    cyc(3);
    wr(lfr_pkg::A_CTRL, 32'h4);
    cyc(6);
    chk({s[4], s[2], s[0]}, 3'h7);
    ahb(1'b0, lfr_pkg::A_RIP, 32'h0, r);
    chk(r, 32'hFF);
    wol_mng_keep <= 1'b1;
    clr();
    wr(lfr_pkg::A_CTRL, 32'h6);
    cyc(3);
    wr(lfr_pkg::A_CTRL, 32'h4);
    cyc(6);
    chk({s[4], s[2], s[0]}, 3'h5);
    wol_mng_keep <= 1'b0;
    $display("pre-reset test done");
  endtask : t_pre
  task automatic t_vf();
    wr(lfr_pkg::A_CTRL, 32'h5);
    wr(lfr_pkg::A_CMD, b(lfr_pkg::CMD_CFGDONE));
    cyc(4);
    chk(vf_gate, 8'h00);
    malicious <= 8'h02;
    clr();
    malicious <= 8'h00;
    wr(lfr_pkg::A_VFCMD, 32'h6);
    cyc(8);
    chk({vf_gate, vc, vd}, 24'h060606);
    chk({s[4], vf_blocked}, 9'h002);
    clr();
    wr(lfr_pkg::A_VFCMD, b(lfr_pkg::VFCMD_SOFT + 5));
    cyc(8);
    chk({vr, vc}, 16'h2000);
    wr(lfr_pkg::A_CTRL, 32'h4);
    cyc(4);
    chk(vf_gate, 8'hFF);
    clr();
    wr(lfr_pkg::A_CMD, b(lfr_pkg::CMD_D3D0));
    cyc(4);
    chk(s[6:4], 3'h5);
    $display("vf test done");
  endtask : t_vf
  task automatic t_sw();
    tc_xon_in <= 1'b1;
    clr();
    wr(lfr_pkg::A_CMD, b(lfr_pkg::CMD_SW));
    cyc(260);
    chk({s[7], s[4], rx_pause_en}, 3'h0);
    tc_xon_in <= 1'b0;
    cyc(230);
    chk(s[7:4], 4'hD);
    clr();
    wr(lfr_pkg::A_CMD, b(lfr_pkg::CMD_LINK));
    cyc(440);
    chk({s[6], s[4:1]}, 5'h1F);
    $display("soft reset test done");
  endtask : t_sw
  task automatic t_phy();
    logic [31:0] r;
    veto_in <= 1'b1;
    clr();
    wr(lfr_pkg::A_CMD, b(lfr_pkg::CMD_PHY) | b(lfr_pkg::CMD_PHYSKIP));
    cyc(8);
    ahb(1'b0, lfr_pkg::A_STAT, 32'h0, r);
    chk({r[4], s[2]}, 2'h2);
    wr(lfr_pkg::A_CMD, b(lfr_pkg::CMD_PHY));
    cyc(20);
    chk(s[2], 1'b0);
    veto_in <= 1'b0;
    cyc(8);
    chk(s[3:2], 2'h3);
    force_rst_en <= 1'b0;
    clr();
    wr(lfr_pkg::A_MGMT, b(lfr_pkg::MGMT_CMD) | 32'h1);
    cyc(2);
    force_rst_en <= 1'b1;
    wr(lfr_pkg::A_MGMT, b(lfr_pkg::MGMT_CMD));
    cyc(5);
    chk(s[1], 1'b0);
    wr(lfr_pkg::A_MGMT, b(lfr_pkg::MGMT_CMD) | 32'h1);
    cyc(5);
    chk(s[1], 1'b1);
    $display("phy and forced reset test done");
  endtask : t_phy
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    cyc(2);
    chk({req_issue_en, vf_gate}, 9'h1FF);
    cyc(3);
    hresetn <= 1'b1;
    cyc(2);
    t_flr(1'b1, 8'h05, 1);
    t_flr(1'b0, 8'h00, 1);
    t_flr(1'b0, 8'h04, 4);
    t_pre();
    t_vf();
    t_sw();
    t_phy();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
